// ### inc/trig_exp_pkg.sv
// constants and carrier types of the frame trigger and exposure controller
package trig_exp_pkg;

	//------------------------------------------------------------
	// timing: raw ticks and core clock
	//------------------------------------------------------------
	localparam int TICKS_PER_US     = 125;  // raw ticks per microsecond
	localparam int CORE_CLK_MHZ     = 250;  // core_clk rate in MHz
	localparam int CYCLES_PER_TICK  = CORE_CLK_MHZ / TICKS_PER_US;
	localparam int TICK_DIV_W       = 2;    // divider counter width

	//------------------------------------------------------------
	// limits and reset values
	//------------------------------------------------------------
	localparam logic [31:0] DELAY_MAX_TICKS   = 32'h0EE6_B280; // 250000000
	localparam logic [31:0] EXPOSURE_MAX_TICKS = 32'h0773_5940; // 125000000
	localparam logic [31:0] EXPOSURE_MIN_TICKS = 32'h0000_000C; // 12
	localparam logic [7:0]  BURST_RESET       = 8'h00;
	localparam logic [31:0] DELAY_RESET       = 32'h0000_0000;

	//------------------------------------------------------------
	// encodings
	//------------------------------------------------------------
	localparam logic [2:0] SEQ_EDGE  = 3'h0; // one exposure per edge
	localparam logic [2:0] SEQ_LEVEL = 3'h1; // pulse width exposure
	localparam logic [2:0] SEQ_BULK  = 3'h6; // several frames per trigger

	typedef enum logic [1:0] {
		ORIGIN_ISO_A = 2'h0,  // isolated input a, default
		ORIGIN_ISO_B = 2'h1,  // isolated input b
		ORIGIN_LINK  = 2'h2,  // link trigger input
		ORIGIN_SOFT  = 2'h3   // soft fire command
	} origin_type;

	// one-hot sequencer states
	typedef enum logic [3:0] {
		ST_WAIT   = 4'b0001,  // waiting for a trigger or frame start
		ST_DELAY  = 4'b0010,  // trigger to exposure delay
		ST_EXPOSE = 4'b0100,  // sensor exposing
		ST_GAP    = 4'b1000   // rest of frame period
	} seq_state_type;

	// software configuration, all fields held by the host side
	typedef struct packed {
		logic        shutter_sync_select;       // 0 free run, 1 trigger
		logic [2:0]  exposure_sequence_select;  // edge, level, bulk
		origin_type  trigger_origin_select;     // trigger origin
		logic        hw_edge_polarity;          // 0 rising/high, 1 fall/low
		logic        exposure_manual;           // 0 from frame rate
		logic [7:0]  burst_frame_count;         // frames per bulk trigger
		logic [31:0] trigger_to_exposure_delay; // raw ticks
		logic [31:0] exposure_duration;         // raw ticks
		logic [31:0] frame_rate_setting;        // frame period, raw ticks
	} cfg_type;

	// sequencer status toward the sensor timing logic
	typedef struct packed {
		logic exposure_active; // sensor exposing
		logic frame_start;     // one-cycle pulse at exposure start
		logic trigger_wait;    // ready for a trigger
		logic config_error;    // unsupported sequence or combination
	} status_type;

endpackage

// ### rtl/frame_trigger_exposure_ctrl.sv
// frame trigger, delay, exposure and bulk sequencer
//
// Overview of operation
// - off is free run, on is triggered
// - edge 0, level 1, bulk 6; others rejected
// - origin is input a, input b, link, software
// - polarity selects active hardware edge
// - bulk frame count 0 to 255, reset 0
// - bulk count ignored outside bulk mode
// - delay 0 to 250000000 ticks before exposure
// - delay applies to hardware and software triggers
// - soft fire starts a triggered exposure sequence
// - soft fire latency is not fixed
// - 32-bit exposure duration, 12 to 125000000 ticks
// - exposure from frame rate or from duration
// - edge mode: one timed exposure per edge
// - level mode exposes while trigger stays active
// - bulk mode exposes several frames per trigger
`timescale 1ns/100ps

module frame_trigger_exposure_ctrl
	import trig_exp_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// configuration from the feature registers
	input  wire cfg_type    cfg,
	input  wire logic       soft_fire_command,
	// trigger pins, asynchronous
	input  wire logic       iso_input_a,
	input  wire logic       iso_input_b,
	input  wire logic       link_trigger_input,
	// status toward the sensor timing
	output status_type      status
);

	//------------------------------------------------------------
	// helper functions
	//------------------------------------------------------------
	// clamp a raw tick value between two bounds
	function automatic logic [31:0] clamp(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	// larger of two tick counts
	function automatic logic [31:0] max32(input logic [31:0] a,
		input logic [31:0] b);
		return (a > b) ? a : b;
	endfunction

	//------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------
	logic [2:0] pin_meta_ff;  // first stage, read by second only
	logic [2:0] pin_sync_ff;  // stable pin levels
	logic       hw_act_ff;    // previous active level of chosen pin

	// two flops before any logic sees the pins
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_meta_ff <= 3'h0;
			pin_sync_ff <= 3'h0;
		end else begin
			pin_meta_ff <= {link_trigger_input, iso_input_b, iso_input_a};
			pin_sync_ff <= pin_meta_ff;
		end
	end

	//------------------------------------------------------------
	// trigger selection
	//------------------------------------------------------------
	logic       sel_level;    // chosen pin, raw level
	logic       hw_act;       // chosen pin at its active level
	logic       is_hw_origin; // input a or b
	logic       seq_ok;       // supported sequence code
	logic       combo_ok;     // sequence and origin may be combined
	logic       trig_event;   // accepted trigger this cycle

	// pick the origin and apply polarity
	always_comb begin
		unique case (cfg.trigger_origin_select)
			ORIGIN_ISO_A: sel_level = pin_sync_ff[0];
			ORIGIN_ISO_B: sel_level = pin_sync_ff[1];
			ORIGIN_LINK:  sel_level = pin_sync_ff[2];
			ORIGIN_SOFT:  sel_level = 1'b0;
		endcase
		hw_act       = sel_level ^ cfg.hw_edge_polarity;
		is_hw_origin = (cfg.trigger_origin_select == ORIGIN_ISO_A) ||
			(cfg.trigger_origin_select == ORIGIN_ISO_B);
		seq_ok = (cfg.exposure_sequence_select == SEQ_EDGE) ||
			(cfg.exposure_sequence_select == SEQ_LEVEL) ||
			(cfg.exposure_sequence_select == SEQ_BULK);
		combo_ok = seq_ok && ((cfg.exposure_sequence_select != SEQ_LEVEL)
			|| is_hw_origin);
		if (cfg.trigger_origin_select == ORIGIN_SOFT) begin
			trig_event = soft_fire_command;
		end else begin
			trig_event = hw_act && !hw_act_ff;
		end
		trig_event = trig_event && combo_ok && cfg.shutter_sync_select;
	end

	// remember the active level for edge detection
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hw_act_ff <= 1'b0;
		end else begin
			hw_act_ff <= hw_act;
		end
	end

	//------------------------------------------------------------
	// tick divider: one raw tick every few core cycles
	//------------------------------------------------------------
	logic [TICK_DIV_W-1:0] div_ff;  // divider count
	logic                  tick_en; // one-cycle tick enable

	assign tick_en = (div_ff == TICK_DIV_W'(CYCLES_PER_TICK - 1));

	// free running divider
	always_ff @(posedge core_clk) begin
		if (!rst_n || tick_en) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 1'b1;
		end
	end

	//------------------------------------------------------------
	// derived lengths
	//------------------------------------------------------------
	logic [31:0] delay_len;  // clamped trigger delay
	logic [31:0] exp_len;    // exposure length in ticks
	logic [31:0] frame_len;  // frame period, exposure has priority
	logic        is_level;   // level mode active
	logic        is_bulk;    // bulk mode active

	always_comb begin
		delay_len = clamp(cfg.trigger_to_exposure_delay, DELAY_RESET,
			DELAY_MAX_TICKS);
		exp_len = cfg.exposure_manual ?
			clamp(cfg.exposure_duration, EXPOSURE_MIN_TICKS,
				EXPOSURE_MAX_TICKS) :
			cfg.frame_rate_setting;
		frame_len = max32(cfg.frame_rate_setting, exp_len);
		is_level  = cfg.exposure_sequence_select == SEQ_LEVEL;
		is_bulk   = cfg.exposure_sequence_select == SEQ_BULK;
	end

	//------------------------------------------------------------
	// sequencer
	//------------------------------------------------------------
	seq_state_type state_ff;     // current state
	seq_state_type nxt_state;    // next state
	logic [31:0]   cnt_ff;       // ticks spent in current state
	logic [31:0]   frame_cnt_ff; // ticks since frame start
	logic [7:0]    burst_ff;     // bulk frames still to expose
	logic          run_level_ff; // running sequence is level mode
	logic          exp_done;     // exposure finished this cycle

	// level exposures end with the pulse, others by count
	assign exp_done = run_level_ff ? !hw_act :
		(cnt_ff >= exp_len);

	// next state decision
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_WAIT: begin
				if (!cfg.shutter_sync_select) begin
					nxt_state = ST_EXPOSE;
				end else if (trig_event) begin
					nxt_state = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (cnt_ff >= delay_len) begin
					nxt_state = ST_EXPOSE;
				end
			end
			ST_EXPOSE: begin
				if (exp_done) begin
					if (!cfg.shutter_sync_select || burst_ff != 8'h00) begin
						nxt_state = ST_GAP;
					end else begin
						nxt_state = ST_WAIT;
					end
				end
			end
			ST_GAP: begin
				if (frame_cnt_ff >= frame_len) begin
					if (burst_ff != 8'h00 || !cfg.shutter_sync_select) begin
						nxt_state = ST_EXPOSE;
					end else begin
						nxt_state = ST_WAIT;
					end
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_ff <= ST_WAIT;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// per-state tick counter, restarts on every state change
	always_ff @(posedge core_clk) begin
		if (!rst_n || nxt_state != state_ff) begin
			cnt_ff <= '0;
		end else if (tick_en && cnt_ff != '1) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// frame period counter, restarts at each exposure start
	always_ff @(posedge core_clk) begin
		if (!rst_n || (nxt_state == ST_EXPOSE && state_ff != ST_EXPOSE)) begin
			frame_cnt_ff <= '0;
		end else if (tick_en && frame_cnt_ff != '1) begin
			frame_cnt_ff <= frame_cnt_ff + 1'b1;
		end
	end

	// bulk frames left; zero counts as a single frame
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			burst_ff <= BURST_RESET;
		end else if (state_ff == ST_WAIT && trig_event) begin
			burst_ff <= (is_bulk && cfg.burst_frame_count != 8'h00) ?
				cfg.burst_frame_count - 8'h01 : 8'h00;
		end else if (state_ff == ST_GAP && nxt_state == ST_EXPOSE &&
			burst_ff != 8'h00) begin
			burst_ff <= burst_ff - 8'h01;
		end
	end

	// sequence mode captured at trigger acceptance
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			run_level_ff <= 1'b0;
		end else if (state_ff == ST_WAIT) begin
			run_level_ff <= trig_event && is_level;
		end
	end

	//------------------------------------------------------------
	// registered outputs
	//------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			status <= '0;
		end else begin
			status.exposure_active <= nxt_state == ST_EXPOSE;
			status.frame_start     <= nxt_state == ST_EXPOSE &&
				state_ff != ST_EXPOSE;
			status.trigger_wait    <= nxt_state == ST_WAIT &&
				cfg.shutter_sync_select;
			status.config_error    <= !combo_ok;
		end
	end

	//------------------------------------------------------------
	// assertions
	//------------------------------------------------------------
	property p_free_run_no_trigger;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == ST_WAIT && !cfg.shutter_sync_select)
			|=> state_ff == ST_EXPOSE;
	endproperty
	a_free_run_no_trigger: assert property (p_free_run_no_trigger)
		else $error("free run did not start an exposure");

	property p_reject_bad_seq;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == ST_WAIT && !seq_ok) |=> state_ff != ST_DELAY;
	endproperty
	a_reject_bad_seq: assert property (p_reject_bad_seq)
		else $error("unsupported sequence code was accepted");

	property p_level_needs_hw;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == ST_WAIT && is_level && !is_hw_origin)
			|=> state_ff != ST_DELAY;
	endproperty
	a_level_needs_hw: assert property (p_level_needs_hw)
		else $error("level mode started from a non hardware origin");

	property p_soft_fire;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == ST_WAIT && cfg.shutter_sync_select && combo_ok &&
			cfg.trigger_origin_select == ORIGIN_SOFT && soft_fire_command)
			|=> state_ff == ST_DELAY ##[0:2] status.trigger_wait == 1'b0;
	endproperty
	a_soft_fire: assert property (p_soft_fire)
		else $error("soft fire did not start a sequence");

	property p_delay_holds;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == ST_DELAY && cnt_ff < delay_len && $stable(cfg))
			|=> state_ff == ST_DELAY;
	endproperty
	a_delay_holds: assert property (p_delay_holds)
		else $error("exposure began before the delay elapsed");

	property p_edge_length;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == ST_EXPOSE && !run_level_ff && cnt_ff < exp_len)
			|=> state_ff == ST_EXPOSE && status.exposure_active;
	endproperty
	a_edge_length: assert property (p_edge_length)
		else $error("timed exposure ended early");

	property p_level_end;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == ST_EXPOSE && run_level_ff && !hw_act)
			|=> state_ff != ST_EXPOSE && !status.exposure_active;
	endproperty
	a_level_end: assert property (p_level_end)
		else $error("level exposure outlived the trigger pulse");

	property p_bulk_next;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == ST_EXPOSE && exp_done && burst_ff != 8'h00)
			|=> state_ff == ST_GAP;
	endproperty
	a_bulk_next: assert property (p_bulk_next)
		else $error("bulk sequence stopped before its frame count");

endmodule

// ### sim/trig_source_model.sv
// external trigger source model driving the three trigger pins
`timescale 1ns/100ps

module trig_source_model (
	// pulse requests from the bench, one bit per pin
	input  wire logic [2:0] act,
	input  wire logic       pol,
	// trigger pins toward the device
	output logic            iso_input_a,
	output logic            iso_input_b,
	output logic            link_trigger_input
);
	//--------------------------------------------------
	// pin levels
	//--------------------------------------------------
	// idle is the inactive level, so a low-active setup idles high
	assign {link_trigger_input, iso_input_b, iso_input_a} =
		act ^ {3{pol}};
endmodule

// ### sim/tb_frame_trigger_exposure_ctrl.sv
// self-checking bench of the frame trigger and exposure controller
`timescale 1ns/100ps

module tb_frame_trigger_exposure_ctrl;
	import trig_exp_pkg::*;

	//--------------------------------------------------
	// bench signals
	//--------------------------------------------------
	logic       core_clk;          // 250 MHz core clock
	logic       rst_n;             // synchronous reset
	cfg_type    cfg;               // host configuration
	logic       soft_fire_command; // soft fire pulse
	logic [2:0] act;               // pin pulse requests
	logic       pin_a;             // isolated input a
	logic       pin_b;             // isolated input b
	logic       pin_l;             // link trigger
	status_type status;            // device status
	int         err_total;         // mismatches
	int         comparisons;       // checks made
	int         cyc;               // timeout counter
	int         frames;            // frame starts in a window
	int         exp_cyc;           // exposing cycles in a window
	int         first;             // window cycle of first frame start

	trig_source_model u_src (
		.act                (act),
		.pol                (cfg.hw_edge_polarity),
		.iso_input_a        (pin_a),
		.iso_input_b        (pin_b),
		.link_trigger_input (pin_l)
	);

	frame_trigger_exposure_ctrl u_dut (
		.core_clk           (core_clk),
		.rst_n              (rst_n),
		.cfg                (cfg),
		.soft_fire_command  (soft_fire_command),
		.iso_input_a        (pin_a),
		.iso_input_b        (pin_b),
		.link_trigger_input (pin_l),
		.status             (status)
	);

	//--------------------------------------------------
	// clock and hang guard
	//--------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// a stuck run is cut after far more cycles than the tests need
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			close_out();
		end
	end

	//--------------------------------------------------
	// shared tasks
	//--------------------------------------------------
	task automatic close_out();
		if (err_total == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// checks that a measured count falls in a window
	task automatic rng(input string name, input int v, input int lo,
		input int hi);
		chk(name, 32'(v >= lo && v <= hi), 32'h0000_0001);
	endtask

	// defaults: triggered, edge, soft origin, short manual exposure
	task automatic setup();
		cfg = '0;
		cfg.shutter_sync_select = 1'b1;
		cfg.exposure_sequence_select = SEQ_EDGE;
		cfg.trigger_origin_select = ORIGIN_SOFT;
		cfg.exposure_manual = 1'b1;
		cfg.exposure_duration = 32'h0000_000C;
		cfg.frame_rate_setting = 32'h0000_0014;
	endtask

	task automatic settle();
		repeat (100) @(negedge core_clk);
	endtask

	task automatic fire_soft();
		@(negedge core_clk);
		soft_fire_command = 1'b1;
		@(negedge core_clk);
		soft_fire_command = 1'b0;
	endtask

	task automatic fire_pin(input int idx, input int hold);
		@(negedge core_clk);
		act[idx] = 1'b1;
		repeat (hold) @(negedge core_clk);
		act[idx] = 1'b0;
	endtask

	// counts frame starts and exposing cycles over n cycles
	task automatic watch(input int n);
		frames = 0;
		exp_cyc = 0;
		first = 0;
		for (int i = 1; i <= n; i++) begin
			@(negedge core_clk);
			if (status.frame_start === 1'b1) begin
				frames++;
				if (first == 0) first = i;
			end
			if (status.exposure_active === 1'b1) exp_cyc++;
		end
	endtask

	//--------------------------------------------------
	// scenarios
	//--------------------------------------------------
	// free run keeps its frame period and ignores pin pulses
	task automatic t_free_run();
		fork
			watch(400);
			fire_pin(0, 4);
		join
		rng("free run frames", frames, 9, 11);
		chk("free run wait", status.trigger_wait, 1'b0);
	endtask

	// soft fire with no delay and with a delay of 10 ticks
	task automatic t_soft_delay(input int d);
		setup();
		cfg.trigger_to_exposure_delay = 32'(d);
		settle();
		chk("waiting", status.trigger_wait, 1'b1);
		fire_soft();
		watch(100);
		chk("soft frames", frames, 32'h0000_0001);
		rng("soft latency", first, (d == 0) ? 1 : 2 * d, 2 * d + 12);
		rng("edge length", exp_cyc, 22, 26);
	endtask

	// each hardware origin and polarity, with delay, wrong pin ignored
	task automatic t_origin(input int o, input logic p);
		setup();
		cfg.trigger_origin_select = origin_type'(o);
		cfg.hw_edge_polarity = p;
		cfg.trigger_to_exposure_delay = 32'h0000_0005;
		settle();
		fork
			watch(100);
			fire_pin((o + 1) % 3, 4);
		join
		chk("other pin", frames, 32'h0000_0000);
		fork
			watch(100);
			fire_pin(o, 4);
		join
		chk("pin frames", frames, 32'h0000_0001);
		rng("pin delay", first, 13, 22);
	endtask

	// bulk count honoured only in bulk mode; zero gives one frame
	task automatic t_bulk(input logic [2:0] seq, input int n, input int e);
		setup();
		cfg.exposure_sequence_select = seq;
		cfg.burst_frame_count = 8'(n);
		settle();
		fire_soft();
		watch(300);
		chk("bulk frames", frames, 32'(e));
	endtask

	// level mode exposes for the pulse width
	task automatic t_level();
		setup();
		cfg.exposure_sequence_select = SEQ_LEVEL;
		cfg.trigger_origin_select = ORIGIN_ISO_A;
		settle();
		fork
			watch(120);
			fire_pin(0, 40);
		join
		chk("level frames", frames, 32'h0000_0001);
		rng("level length", exp_cyc, 35, 44);
	endtask

	// exposure length taken from the frame rate setting
	task automatic t_from_rate();
		setup();
		cfg.exposure_manual = 1'b0;
		cfg.frame_rate_setting = 32'h0000_000F;
		settle();
		fire_soft();
		watch(100);
		rng("rate length", exp_cyc, 28, 32);
	endtask

	// unsupported codes and combinations are flagged and ignored
	task automatic t_bad(input logic [2:0] seq, input origin_type o,
		input logic e);
		setup();
		cfg.exposure_sequence_select = seq;
		cfg.trigger_origin_select = o;
		settle();
		chk("config error", status.config_error, e);
		fire_soft();
		watch(60);
		chk("bad frames", frames, 32'(!e));
	endtask

	//--------------------------------------------------
	// main sequence
	//--------------------------------------------------
	initial begin
		rst_n = 1'b0;
		soft_fire_command = 1'b0;
		act = 3'h0;
		setup();
		cfg.shutter_sync_select = 1'b0;
		repeat (19) @(negedge core_clk);
		chk("status in reset", 32'(status), 32'h0000_0000);
		@(negedge core_clk);
		rst_n = 1'b1;
		t_free_run();
		t_soft_delay(0);
		t_soft_delay(10);
		for (int o = 0; o < 3; o++) begin
			t_origin(o, 1'b0);
			t_origin(o, 1'b1);
		end
		t_bulk(SEQ_BULK, 3, 3);
		t_bulk(SEQ_BULK, 0, 1);
		t_bulk(SEQ_EDGE, 3, 1);
		t_level();
		t_from_rate();
		for (int c = 2; c < 8; c++) begin
			if (c != 6) t_bad(3'(c), ORIGIN_SOFT, 1'b1);
		end
		t_bad(SEQ_LEVEL, ORIGIN_SOFT, 1'b1);
		t_bad(SEQ_LEVEL, ORIGIN_LINK, 1'b1);
		t_bad(SEQ_EDGE, ORIGIN_SOFT, 1'b0);
		close_out();
	end
endmodule
